// *** rtl/det_timer.sv ***
// dual eight-bit timer: basic timer with rtc, event timer with reload and buzzer
//
// Summary of operation
// - basic timer counts only while run bit set
// - basic count increments per tick, wraps overflow
// - overflow sets sticky basic flag, software clears
// - basic counter never reloads itself
// - enabled basic overflow requests vector eight
// - green mode basic overflow wakes system
// - basic prescale divides cpu clock 256..2
// - rtc select uses slow oscillator over 64
// - rtc mode ignores prescale, full 256 count
// - rtc mode only with rc rtc option
// - event timer counts only while run bit
// - event wrap sets sticky event flag
// - event overflow always reloads from reload buffer
// - enabled event overflow requests vector 0x0C
// - event timer runs in green, never wakes
// - external select counts pin, ignores prescale
// - event prescale on cpu or fast oscillator
// - fast select lives in basic mode bit1
// - buzzer toggles each event overflow
// - external mode counts pin falling edges
`timescale 1ns/1ps
`default_nettype none
module det_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // clock enables
  input wire logic cpu_en,
  input wire logic hosc_en,
  input wire logic lsosc_en,
  // configuration and power state
  input wire logic internal_rc_rtc_option,
  input wire logic green_mode,
  // external event pin
  input wire logic ext_event_pin,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // interrupt request and wake
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic wake_req,
  // buzzer
  output logic buzzer_out,
  output logic buzzer_oe
);
  import det_pkg::*;

  // ***************
  // state
  // ***************
  typedef struct packed {
    logic [7:0] basic_mode_reg;
    logic [7:0] basic_count;
    logic [7:0] event_mode;
    logic [7:0] event_count;
    logic [7:0] event_reload_buf;
    logic [7:0] event_reload;
    logic basic_overflow_flag;
    logic basic_irq_enable;
    logic event_overflow_flag;
    logic event_irq_enable;
    logic buzz;
    logic wake;
    logic [1:0] ext_sync;
    logic ext_prev;
    logic [7:0] rtc_div;
    logic [7:0] rdata;
  } det_state_t;
  det_state_t state;
  det_state_t next_state;

  logic basic_run_bit;
  logic rtc_clock_sel;
  logic event_run_bit;
  logic ext_clock_sel;
  logic fast_clock_sel;
  logic rtc_active;
  logic basic_ps_tick;
  logic rtc_tick;
  logic event_ps_tick;
  logic basic_tick;
  logic event_tick;
  logic ext_fall;
  logic basic_ovf;
  logic event_ovf;
  logic rtc_div_tick;
  logic [7:0] irq_ctrl;

  assign basic_run_bit = state.basic_mode_reg[DET_RUN_BIT];
  assign rtc_clock_sel = state.basic_mode_reg[DET_RTC_SEL_BIT];
  assign fast_clock_sel = state.basic_mode_reg[DET_FAST_SEL_BIT];
  assign event_run_bit = state.event_mode[DET_RUN_BIT];
  assign ext_clock_sel = state.event_mode[DET_EXT_SEL_BIT];
  assign rtc_active = rtc_clock_sel && internal_rc_rtc_option;

  // ***************
  // clock selection
  // ***************
  det_prescaler u_basic_ps (
    .clk(clk),
    .rst(rst),
    .src_en(cpu_en),
    .rate(state.basic_mode_reg[DET_RATE_LSB +: 3]),
    .shift_down(1'b0),
    .tick(basic_ps_tick)
  );

  // slow oscillator over 64 for the half-second rtc period
  assign rtc_div_tick = lsosc_en && (state.rtc_div == DET_RTC_DIV - DET_ONE);
  assign rtc_tick = rtc_div_tick;

  det_prescaler u_event_ps (
    .clk(clk),
    .rst(rst),
    .src_en(fast_clock_sel ? hosc_en : cpu_en),
    .rate(state.event_mode[DET_RATE_LSB +: 3]),
    .shift_down(fast_clock_sel),
    .tick(event_ps_tick)
  );

  assign basic_tick = rtc_active ? rtc_tick : basic_ps_tick;
  // only the second stage feeds the edge detector
  assign ext_fall = state.ext_prev && !state.ext_sync[1];
  assign event_tick = ext_clock_sel ? ext_fall : event_ps_tick;
  assign basic_ovf = basic_run_bit && basic_tick
    && (state.basic_count == DET_FULL_SCALE);
  assign event_ovf = event_run_bit && event_tick
    && (state.event_count == DET_FULL_SCALE);

  assign irq_ctrl = {4'h0, state.event_irq_enable, state.event_overflow_flag,
    state.basic_irq_enable, state.basic_overflow_flag};

  // ***************
  // next state
  // ***************
  always_comb begin
    next_state = state;
    next_state.ext_sync = {state.ext_sync[0], ext_event_pin};
    next_state.ext_prev = state.ext_sync[1];
    next_state.rdata = DET_RESET_VALUE;
    next_state.wake = 1'b0;
    if (lsosc_en) begin
      next_state.rtc_div = rtc_div_tick ? DET_RESET_VALUE : state.rtc_div + DET_ONE;
    end
    // software writes first, hardware events override below
    if (reg_write) begin
      unique case (reg_addr)
        DET_ADDR_BASIC_MODE: next_state.basic_mode_reg = reg_wdata & DET_BASIC_MODE_MASK;
        DET_ADDR_BASIC_COUNT: next_state.basic_count = reg_wdata;
        DET_ADDR_EVENT_MODE: next_state.event_mode = reg_wdata & DET_EVENT_MODE_MASK;
        DET_ADDR_EVENT_COUNT: next_state.event_count = reg_wdata;
        DET_ADDR_EVENT_RELOAD: next_state.event_reload_buf = reg_wdata;
        DET_ADDR_IRQ_CTRL: begin
          next_state.basic_overflow_flag = reg_wdata[DET_BOVF_BIT];
          next_state.basic_irq_enable = reg_wdata[DET_BIEN_BIT];
          next_state.event_overflow_flag = reg_wdata[DET_EOVF_BIT];
          next_state.event_irq_enable = reg_wdata[DET_EIEN_BIT];
        end
        default: ;
      endcase
    end
    if (basic_run_bit && basic_tick) begin
      // wraps to zero; software must reload the interval
      next_state.basic_count = state.basic_count + DET_ONE;
    end
    if (basic_ovf) begin
      next_state.basic_overflow_flag = 1'b1;
      next_state.wake = green_mode;
    end
    if (event_run_bit && event_tick) begin
      next_state.event_count = state.event_count + DET_ONE;
    end
    if (event_ovf) begin
      // new reload value takes effect only at overflow
      next_state.event_reload = state.event_reload_buf;
      next_state.event_count = state.event_reload_buf;
      next_state.event_overflow_flag = 1'b1;
      next_state.buzz = !state.buzz;
    end
    if (reg_read) begin
      unique case (reg_addr)
        DET_ADDR_BASIC_MODE: next_state.rdata = state.basic_mode_reg;
        DET_ADDR_BASIC_COUNT: next_state.rdata = state.basic_count;
        DET_ADDR_EVENT_MODE: next_state.rdata = state.event_mode;
        DET_ADDR_EVENT_COUNT: next_state.rdata = state.event_count;
        DET_ADDR_IRQ_CTRL: next_state.rdata = irq_ctrl;
        default: next_state.rdata = DET_RESET_VALUE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ***************
  // outputs
  // ***************
  assign reg_rdata = state.rdata;
  // basic source has priority, as the lower vector
  always_comb begin
    irq_req = 1'b0;
    irq_vector = DET_BASIC_VECTOR;
    if (state.basic_irq_enable && state.basic_overflow_flag) begin
      irq_req = 1'b1;
    end else if (state.event_irq_enable && state.event_overflow_flag) begin
      irq_req = 1'b1;
      irq_vector = DET_EVENT_VECTOR;
    end
  end
  assign wake_req = state.wake;
  assign buzzer_out = state.buzz;
  assign buzzer_oe = state.event_mode[DET_BUZZ_EN_BIT];
endmodule
`default_nettype wire

// *** rtl/det_pkg.sv ***
// constants shared by the dual eight-bit timer design
package det_pkg;
  // ***************
  // register map
  // ***************
  localparam logic [7:0] DET_ADDR_BASIC_MODE = 8'hD8;
  localparam logic [7:0] DET_ADDR_BASIC_COUNT = 8'hD9;
  localparam logic [7:0] DET_ADDR_EVENT_MODE = 8'hDA;
  localparam logic [7:0] DET_ADDR_EVENT_COUNT = 8'hDB;
  localparam logic [7:0] DET_ADDR_EVENT_RELOAD = 8'hCD;
  localparam logic [7:0] DET_ADDR_IRQ_CTRL = 8'hC0;
  // ***************
  // field positions
  // ***************
  localparam int DET_RUN_BIT = 7;
  localparam int DET_RATE_LSB = 4;
  localparam int DET_FAST_SEL_BIT = 1;
  localparam int DET_RTC_SEL_BIT = 0;
  localparam int DET_EXT_SEL_BIT = 3;
  localparam int DET_BUZZ_EN_BIT = 1;
  localparam int DET_BOVF_BIT = 0;
  localparam int DET_BIEN_BIT = 1;
  localparam int DET_EOVF_BIT = 2;
  localparam int DET_EIEN_BIT = 3;
  // ***************
  // masks and values
  // ***************
  localparam logic [7:0] DET_BASIC_MODE_MASK = 8'hF3;
  localparam logic [7:0] DET_EVENT_MODE_MASK = 8'hFA;
  localparam logic [7:0] DET_RESET_VALUE = 8'h00;
  localparam logic [7:0] DET_FULL_SCALE = 8'hFF;
  localparam logic [7:0] DET_ONE = 8'h01;
  localparam logic [7:0] DET_RTC_DIV = 8'h40;
  localparam logic [7:0] DET_DIV_TOP = 8'hFF;
  localparam logic [15:0] DET_BASIC_VECTOR = 16'h0008;
  localparam logic [15:0] DET_EVENT_VECTOR = 16'h000C;
endpackage

// *** rtl/det_prescaler.sv ***
// free-running divider producing one-cycle enables at power-of-two rates
`timescale 1ns/1ps
`default_nettype none
module det_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // source enable and rate
  input wire logic src_en,
  input wire logic [2:0] rate,
  input wire logic shift_down,
  // divided enable
  output logic tick
);
  import det_pkg::*;
  typedef struct packed {
    logic [7:0] cnt;
  } det_ps_state_t;
  det_ps_state_t state;
  det_ps_state_t next_state;
  logic [7:0] mask;
  // code 0 divides by 256 (or 128 shifted), each step halves
  always_comb begin
    mask = DET_DIV_TOP >> rate;
    if (shift_down) begin
      mask = mask >> 1;
    end
    next_state = state;
    if (src_en) begin
      next_state.cnt = state.cnt + DET_ONE;
    end
  end
  assign tick = src_en && ((state.cnt & mask) == mask);
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule
`default_nettype wire

// *** sim/det_timer_properties.sv ***
// port assertions for the dual eight-bit timer
`timescale 1ns/1ps
`default_nettype none
module det_timer_properties
  import det_pkg::*;
(
  // clock, reset, power state, register port
  input wire logic clk,
  input wire logic rst,
  input wire logic green_mode,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // outputs
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic wake_req,
  input wire logic buzzer_out,
  input wire logic buzzer_oe
);
  logic b_run, e_run, e_buz, b_ien, e_ien, irq_wr;
  assign irq_wr = reg_write && reg_addr == DET_ADDR_IRQ_CTRL;
  // shadows with the same one-cycle write latency as the block
  always_ff @(posedge clk) begin
    if (rst) begin
      b_run <= 1'b0;
      e_run <= 1'b0;
      e_buz <= 1'b0;
      b_ien <= 1'b0;
      e_ien <= 1'b0;
    end else if (reg_write && reg_addr == DET_ADDR_BASIC_MODE) begin
      b_run <= reg_wdata[DET_RUN_BIT];
    end else if (reg_write && reg_addr == DET_ADDR_EVENT_MODE) begin
      e_run <= reg_wdata[DET_RUN_BIT];
      e_buz <= reg_wdata[DET_BUZZ_EN_BIT];
    end else if (irq_wr) begin
      b_ien <= reg_wdata[DET_BIEN_BIT];
      e_ien <= reg_wdata[DET_EIEN_BIT];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd_stop;
    reg_read && reg_addr == DET_ADDR_BASIC_COUNT && !b_run;
  endsequence
  property p_hold;
    s_rd_stop ##1 !reg_write ##1 s_rd_stop |=> reg_rdata == $past(reg_rdata, 2);
  endproperty
  a_rd_hold: assert property (p_hold)
    else $error("stopped count moved");
  a_irq_fall: assert property ($fell(irq_req) && !$past(rst) |-> $past(irq_wr))
    else $error("flag dropped alone");
  // a request must name the vector of a source whose enable software set
  a_vec_pair: assert property (irq_req |-> ((irq_vector == DET_BASIC_VECTOR) ? b_ien
    : (irq_vector == DET_EVENT_VECTOR && e_ien)))
    else $error("bad vector");
  a_wake_green: assert property (wake_req |-> $past(green_mode))
    else $error("wake outside green");
  a_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake too long");
  a_wake_basic: assert property (wake_req |-> $past(b_run))
    else $error("wake without basic");
  a_buzz_run: assert property ($changed(buzzer_out) && !$past(rst) |-> $past(e_run))
    else $error("buzzer moved stopped");
  a_buzz_oe: assert property (buzzer_oe == e_buz)
    else $error("buzzer enable wrong");
endmodule
bind det_timer det_timer_properties i_det_timer_properties (
  .clk(clk),
  .rst(rst),
  .green_mode(green_mode),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_write(reg_write),
  .reg_read(reg_read),
  .reg_rdata(reg_rdata),
  .irq_req(irq_req),
  .irq_vector(irq_vector),
  .wake_req(wake_req),
  .buzzer_out(buzzer_out),
  .buzzer_oe(buzzer_oe)
);
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the dual eight-bit timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import det_pkg::*;
  localparam logic [7:0] BM = DET_ADDR_BASIC_MODE, BC = DET_ADDR_BASIC_COUNT;
  localparam logic [7:0] EM = DET_ADDR_EVENT_MODE, EC = DET_ADDR_EVENT_COUNT;
  localparam logic [7:0] ER = DET_ADDR_EVENT_RELOAD, IC = DET_ADDR_IRQ_CTRL;
  logic clk = 1'b0, rst = 1'b1, cpu_en = 1'b1, hosc_en = 1'b1, lsosc_en = 1'b1;
  logic internal_rc_rtc_option = 1'b0, green_mode = 1'b0, ext_event_pin = 1'b1;
  logic reg_write = 1'b0, reg_read = 1'b0, rd_d = 1'b0, wk = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic irq_req, wake_req, buzzer_out, buzzer_oe;
  logic [15:0] irq_vector, e;
  logic [15:0] q[$];
  int err_total = 0, checks = 0, n;
  always #12.5 clk = ~clk;
  det_timer i_det_timer (
    .clk(clk),
    .rst(rst),
    .cpu_en(cpu_en),
    .hosc_en(hosc_en),
    .lsosc_en(lsosc_en),
    .internal_rc_rtc_option(internal_rc_rtc_option),
    .green_mode(green_mode),
    .ext_event_pin(ext_event_pin),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .irq_req(irq_req),
    .irq_vector(irq_vector),
    .wake_req(wake_req),
    .buzzer_out(buzzer_out),
    .buzzer_oe(buzzer_oe)
  );
  task automatic chk(input string s, input logic [15:0] lo, hi, v);
    checks++;
    if (((v >= lo) && (v <= hi)) !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED %s exp %0h..%0h got %0h", s, lo, hi, v);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    reg_write <= w;
    reg_read <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, lo, hi);
    q.push_back({lo, hi});
    acc(1'b0, a, 8'h00);
  endtask
  always @(posedge clk) begin
    rd_d <= reg_read;
  end
  // read data stand only in the cycle after the strobe: look mid-cycle, away from the edge
  always @(negedge clk) begin
    if (wake_req === 1'b1) wk <= 1'b1;
    if (rd_d) begin
      e = q.pop_front();
      chk("reg_rdata", {8'h00, e[15:8]}, {8'h00, e[7:0]}, {8'h00, reg_rdata});
    end
  end
  // prescaler phase is unknown, so one tick either way is allowed
  task automatic span(input logic [7:0] ma, m, ca, input int w, x);
    logic [7:0] b;
    b = 8'($urandom_range(63, 1));
    wr(ca, b);
    wr(ma, m);
    repeat (w) @(posedge clk);
    wr(ma, m & 8'h7F);
    repeat (8) @(posedge clk);
    rd(ca, b + 8'(x) - 8'h01, b + 8'(x) + 8'h01);
  endtask
  task automatic ovf(input logic [7:0] c, m, input logic [15:0] lo, hi, input logic g);
    wr(IC, 8'h02);
    wr(BC, c);
    wk = 1'b0;
    wr(BM, m);
    n = 0;
    while (irq_req !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    rd(BC, 8'h00, 8'h04);
    @(negedge clk);
    chk("interval", lo, hi, 16'(n));
    chk("wake_req", {15'h0000, g}, {15'h0000, g}, {15'h0000, wk});
    chk("irq_vector", DET_BASIC_VECTOR, DET_BASIC_VECTOR, irq_vector);
    wr(BM, 8'h00);
    rd(IC, 8'h03, 8'h03);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    results();
  end
  initial begin
    void'($urandom(66556));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(BM, 8'h00, 8'h00);
    rd(BC, 8'h00, 8'h00);
    rd(BC, 8'h00, 8'h00);
    rd(EM, 8'h00, 8'h00);
    rd(EC, 8'h00, 8'h00);
    rd(ER, 8'h00, 8'h00);
    rd(IC, 8'h00, 8'h00);
    rd(8'h00, 8'h00, 8'h00);
    wr(BM, 8'h0C);
    rd(BM, 8'h00, 8'h00);
    for (int k = 0; k < 8; k++) begin
      span(BM, {1'b1, 3'(k), 4'h0}, BC, 254, 1 << k);
    end
    internal_rc_rtc_option <= 1'b1;
    green_mode <= 1'b1;
    ovf(8'h00, 8'hF1, 16'h3FB0, 16'h4010, 1'b1);
    internal_rc_rtc_option <= 1'b0;
    green_mode <= 1'b0;
    ovf(8'hF0, 8'hF1, 16'h001C, 16'h0028, 1'b0);
    wr(BM, 8'h02);
    span(EM, 8'hF0, EC, 18, 20);
    wr(BM, 8'h00);
    span(EM, 8'hF0, EC, 30, 16);
    wr(BM, 8'h02);
    wr(ER, 8'hFD);
    wr(EC, 8'hFD);
    wr(IC, 8'h08);
    green_mode <= 1'b1;
    wk = 1'b0;
    wr(EM, 8'hFA);
    repeat (4) begin
      repeat (4) @(posedge clk);
      ext_event_pin <= 1'b0;
      repeat (4) @(posedge clk);
      ext_event_pin <= 1'b1;
    end
    repeat (6) @(posedge clk);
    rd(EC, 8'hFE, 8'hFE);
    rd(IC, 8'h0C, 8'h0C);
    rd(ER, 8'h00, 8'h00);
    @(negedge clk);
    chk("buzzer", 16'h0003, 16'h0003, {14'h0000, buzzer_out, buzzer_oe});
    chk("irq_vector", DET_EVENT_VECTOR, DET_EVENT_VECTOR, irq_vector);
    chk("wake_req", 16'h0000, 16'h0000, {15'h0000, wk});
    wr(IC, 8'h00);
    rd(IC, 8'h00, 8'h00);
    repeat (4) @(posedge clk);
    results();
  end
endmodule
`default_nettype wire
